// File: tb/flash_model.sv
// Program flash array seen by the decoder's flash address.
// Assumes a combinational word read, one word per address.
`timescale 1ns/10ps
module flash_model (
	input wire logic [9:0] i_addr,
	output logic [13:0] o_word
);
	// upper bits busy, no write port
	assign o_word = {~i_addr[5:0], i_addr[7:0] ^ 8'hA5};
endmodule

// File: tb/memory_map_decoder_monitor.sv
// Checker bound to the memory map decoder top.
// Assumes one clock and an asynchronous low-active reset.
`timescale 1ns/10ps
module memory_map_decoder_monitor (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_advance,
	input wire logic i_load,
	input wire logic i_interrupt,
	input wire logic i_req,
	input wire logic i_write,
	input wire logic i_indirect,
	input wire logic o_done,
	input wire logic o_stall,
	input wire logic o_high_endurance,
	input wire logic [14:0] i_load_addr,
	input wire logic [14:0] o_pc,
	input wire logic [15:0] i_file_select_pointer,
	input wire logic [13:0] i_flash_word,
	input wire logic [9:0] o_fetch_addr,
	input wire logic [7:0] o_rdata
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	logic fl, ram;
	logic [7:0] lo;
	logic [9:0] fa;
	assign fl = i_ce && i_req && i_indirect && i_file_select_pointer[15]
		&& !o_stall;
	assign ram = i_ce && i_req && !o_stall && !fl;
	assign lo = i_flash_word[7:0];
	assign fa = i_file_select_pointer[9:0];
	pc_wrap_a: assert property (o_fetch_addr == o_pc[9:0])
		else $error("fetch address is not the wrapped pc");
	irq_vector_a: assert property (i_ce && i_interrupt |=>
		o_pc == 15'h0004) else $error("interrupt vector wrong");
	pc_load_a: assert property (i_ce && i_load && !i_interrupt |=>
		o_pc == $past(i_load_addr)) else $error("pc load wrong");
	pc_step_a: assert property (i_ce && i_advance && !i_load &&
		!i_interrupt |=> o_pc == $past(o_pc) + 15'h0001)
		else $error("pc step wrong");
	flash_stall_a: assert property (fl |=>
		o_stall ##1 (o_done && !o_stall)) else $error("flash timing wrong");
	// Flash reads return the low byte of the flash word
	flash_byte_a: assert property (o_done && $past(o_stall) &&
		!$past(i_write) |->
		o_rdata == $past(lo)) else $error("flash byte wrong");
	ram_done_a: assert property (ram |=> o_done && !o_stall)
		else $error("data access timing wrong");
	high_end_a: assert property (fl |=>
		o_high_endurance == ($past(fa) >= 10'h380))
		else $error("high endurance flag wrong");
	cover property (fl ##2 o_done);
	cover property (i_interrupt && i_load);
	cover property (ram ##1 o_rdata == 8'h00);
endmodule
bind memory_map_decoder memory_map_decoder_monitor i_mon (.*);

// File: tb/test_memory_map_decoder.sv
// Self-checking bench for the memory map decoder.
// Assumes a 20 MHz clock and the flash model on the far side.
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
module test_memory_map_decoder;
	logic i_clk = '0, i_rst_b = '0, i_advance = '0, i_load = '0;
	logic i_interrupt = '0, i_req = '0, i_write = '0, i_indirect = '0;
	logic [14:0] i_load_addr = '0, o_pc;
	logic [15:0] i_file_select_pointer = '0;
	logic [4:0] i_bank = '0;
	logic [6:0] i_offset = '0;
	logic [7:0] i_wdata = '0, rd, o_rdata;
	logic [13:0] i_flash_word;
	logic [9:0] o_fetch_addr, o_flash_addr;
	logic o_high_endurance, o_done, o_stall;
	int miscompares = 0, cmp_count = 0;
	memory_map_decoder i_memory_map_decoder (.i_ce(1'h1), .*);
	flash_model i_flash_model (.i_addr(o_flash_addr), .o_word(i_flash_word));
	initial forever #25 i_clk = ~i_clk;
	task automatic step();
		@(posedge i_clk);
		#1;
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Request held through the stall; a lost answer ends the run
	task automatic acc(input logic ind, wr, input logic [15:0] p,
		input logic [6:0] off, input logic [7:0] d, input int lat);
		int n;
		step();
		{i_indirect, i_write, i_file_select_pointer} = {ind, wr, p};
		{i_offset, i_wdata, i_req} = {off, d, 1'h1};
		step();
		n = 1;
		while (o_done !== 1'h1 && n < 4) begin
			step();
			n++;
		end
		i_req = '0;
		rd = o_rdata;
		`CHK("latency", lat, n)
		if (n == 4) print_verdict();
	endtask
	task automatic t_pc();
		`CHK("pc", 15'h0000, o_pc)
		{i_load, i_load_addr} = {1'h1, 15'h7FFF};
		step();
		{i_load, i_advance} = 2'h1;
		`CHK("fetch", 10'h3FF, o_fetch_addr)
		step();
		`CHK("pc", 15'h0000, o_pc)
		{i_interrupt, i_load, i_advance} = 3'h7;
		step();
		{i_interrupt, i_load, i_advance} = 3'h0;
		`CHK("pc", 15'h0004, o_pc)
	endtask
	task automatic t_ram();
		i_bank = 5'h03;
		acc(0, 1, 0, 7'h70, 8'h99, 1);
		i_bank = 5'h00;
		acc(1, 1, 16'h2000, 0, 8'h11, 1);
		acc(1, 1, 16'h202F, 0, 8'h3C, 1);
		acc(1, 1, 16'h2050, 0, 8'h77, 1);
		acc(1, 1, 16'h0030, 0, 8'h5E, 1);
		acc(0, 0, 0, 7'h70, 0, 1);
		`CHK("common", 8'h99, rd)
		acc(0, 0, 0, 7'h20, 0, 1);
		`CHK("linear", 8'h11, rd)
		acc(0, 0, 0, 7'h4F, 0, 1);
		`CHK("linear", 8'h3C, rd)
		acc(1, 0, 16'h2050, 0, 0, 1);
		`CHK("next bank", 8'h00, rd)
		acc(1, 0, 16'h1000, 0, 0, 1);
		`CHK("unmapped", 8'h00, rd)
	endtask
	task automatic t_flash();
		acc(1, 1, 16'h8030, 0, 8'hFF, 2);
		acc(0, 0, 0, 7'h30, 0, 1);
		`CHK("banked", 8'h5E, rd)
		acc(1, 0, 16'h8385, 0, 0, 2);
		`CHK("flash", 8'h20, rd)
		`CHK("endur", 1'h1, o_high_endurance)
		acc(1, 0, 16'h837F, 0, 0, 2);
		`CHK("endur", 1'h0, o_high_endurance)
		`CHK("flash", 8'hDA, rd)
	endtask
	initial begin
		repeat (12) @(posedge i_clk);
		#1 i_rst_b = 1'h1;
		t_pc();
		t_ram();
		t_flash();
		print_verdict();
	end
endmodule

// File: verilog/memory_map_decoder.sv
// Data and program address decoder for an 8-bit core.
// Assumes the core holds a request steady while o_stall is high and that
// flash and RAM answer combinationally on i_flash_word and the RAM array.
`timescale 1ns/10ps
module memory_map_decoder (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_advance,
	input wire logic i_load,
	input wire logic [14:0] i_load_addr,
	input wire logic i_interrupt,
	input wire logic i_req,
	input wire logic i_write,
	input wire logic i_indirect,
	input wire logic [15:0] i_file_select_pointer,
	input wire logic [4:0] i_bank,
	input wire logic [6:0] i_offset,
	input wire logic [7:0] i_wdata,
	input wire logic [13:0] i_flash_word,
	output logic [14:0] o_pc,
	output logic [9:0] o_fetch_addr,
	output logic [9:0] o_flash_addr,
	output logic o_high_endurance,
	output logic [7:0] o_rdata,
	output logic o_done,
	output logic o_stall
);
	logic [7:0] ram [memory_map_pkg::RAM_BYTES];
	memory_map_pkg::access_state_type state;
	memory_map_pkg::access_state_type next_state;
	logic [15:0] lin_off;
	logic [4:0] lin_bank;
	logic [6:0] lin_low;
	logic [4:0] sel_bank;
	logic [6:0] sel_off;
	logic is_flash;
	logic is_linear;
	logic ram_hit;
	logic [5:0] ram_idx;
	logic [6:0] ram_loc;
	logic [7:0] next_rdata;
	logic next_done;
	logic next_stall;
	logic ram_we;

	// ------------------------------------------------------------
	// Program counter
	// ------------------------------------------------------------
	program_counter i_program_counter (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_advance(i_advance),
		.i_load(i_load),
		.i_load_addr(i_load_addr),
		.i_interrupt(i_interrupt),
		.o_pc(o_pc),
		.o_fetch_addr(o_fetch_addr)
	);

	// Maps a banked location onto the small RAM; common bytes share banks
	function automatic logic [6:0] ram_map(input logic [4:0] bank,
		input logic [6:0] off);
		logic [6:0] res;
		res = 7'h7F;
		if (off >= memory_map_pkg::COMMON_FIRST) begin
			res = {3'h0, off[3:0]};
		end else if (bank == 5'h00 &&
			off >= memory_map_pkg::GPR_BLOCK_OFFSET &&
			off < 7'h50) begin
			res = 7'h10 + (off - memory_map_pkg::GPR_BLOCK_OFFSET);
		end
		return res;
	endfunction

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	always_comb begin
		is_flash = i_indirect && i_file_select_pointer[15];
		is_linear = i_indirect && !is_flash &&
			i_file_select_pointer >= memory_map_pkg::LINEAR_FIRST &&
			i_file_select_pointer <= memory_map_pkg::LINEAR_LAST;
		lin_off = i_file_select_pointer - memory_map_pkg::LINEAR_FIRST;
		lin_bank = 5'(lin_off / 16'(memory_map_pkg::GPR_BLOCK_BYTES));
		lin_low = 7'(lin_off % 16'(memory_map_pkg::GPR_BLOCK_BYTES));
		sel_bank = i_bank;
		sel_off = i_offset;
		if (is_linear) begin
			sel_bank = lin_bank;
			sel_off = lin_low + memory_map_pkg::GPR_BLOCK_OFFSET;
		end else if (i_indirect) begin
			sel_bank = i_file_select_pointer[11:7];
			sel_off = i_file_select_pointer[6:0];
		end
		ram_loc = ram_map(sel_bank, sel_off);
		ram_hit = !is_flash && ram_loc != 7'h7F &&
			!(i_indirect && !is_linear &&
			i_file_select_pointer[15:12] != 4'h0);
		ram_idx = ram_loc[5:0];
	end

	// ------------------------------------------------------------
	// Access sequencing
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_rdata = o_rdata;
		next_done = 1'b0;
		next_stall = 1'b0;
		ram_we = 1'b0;
		case (state)
			memory_map_pkg::ACCESS_IDLE: begin
				if (i_req && is_flash) begin
					next_state = memory_map_pkg::ACCESS_STALL;
					next_stall = 1'b1;
				end else if (i_req) begin
					next_done = 1'b1;
					ram_we = i_write && ram_hit;
					next_rdata = ram_hit ? ram[ram_idx] :
						memory_map_pkg::UNIMPLEMENTED_READ;
				end
			end
			memory_map_pkg::ACCESS_STALL: begin
				next_state = memory_map_pkg::ACCESS_IDLE;
				next_done = 1'b1;
				next_rdata = i_write ? o_rdata : i_flash_word[7:0];
			end
			default: begin
				next_state = memory_map_pkg::ACCESS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= memory_map_pkg::ACCESS_IDLE;
			o_rdata <= 8'h00;
			o_done <= 1'b0;
			o_stall <= 1'b0;
			o_flash_addr <= 10'h000;
			o_high_endurance <= 1'b0;
		end else if (i_ce) begin
			state <= next_state;
			o_rdata <= next_rdata;
			o_done <= next_done;
			o_stall <= next_stall;
			o_flash_addr <= i_file_select_pointer[9:0];
			o_high_endurance <= is_flash &&
				{5'h00, i_file_select_pointer[9:0]} >=
				memory_map_pkg::HIGH_ENDURANCE_FIRST;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_ce && ram_we) begin
			ram[ram_idx] <= i_wdata;
		end
	end
endmodule

// File: verilog/memory_map_pkg.sv
// Constants shared by the memory map decoder and its program counter.
// Assumes one instruction-cycle clock and no software-visible registers.
// Summary of operation
// - Program counter is fifteen bits, spanning a 32K-word by 14-bit space.
// - Program addresses beyond word 03FFh wrap into the 1,024 implemented words.
// - Reset starts fetching at word 0000h; interrupts vector to word 0004h.
// - Words 0380h to 03FFh form the 128-byte high-endurance low-byte region.
// - Pointer 0x2000 to 0x29AF maps linearly onto each bank's 80-byte RAM.
// - Stepping past one bank's 80 bytes lands on the next bank's first byte.
// - Reads of unimplemented data memory return 0x00.
// - The 16 shared common bytes are excluded from the linear region.
// - Pointer high bit set selects program memory by the lower fifteen bits.
// - Program memory reads via the data port return only the low byte.
// - Data port writes aimed at program memory never alter flash.
// - Flash access through the pointer costs one extra instruction cycle.
package memory_map_pkg;
	localparam int PC_WIDTH = 15;
	localparam int PROG_ADDR_WIDTH = 10;
	localparam logic [14:0] PROG_LAST_WORD = 15'h03FF;
	localparam logic [14:0] RESET_VECTOR = 15'h0000;
	localparam logic [14:0] INTERRUPT_VECTOR = 15'h0004;
	localparam logic [14:0] HIGH_ENDURANCE_FIRST = 15'h0380;
	localparam logic [14:0] HIGH_ENDURANCE_LAST = 15'h03FF;
	localparam logic [15:0] LINEAR_FIRST = 16'h2000;
	localparam logic [15:0] LINEAR_LAST = 16'h29AF;
	localparam logic [6:0] GPR_BLOCK_BYTES = 7'h50;
	localparam logic [6:0] GPR_BLOCK_OFFSET = 7'h20;
	localparam logic [6:0] COMMON_FIRST = 7'h70;
	localparam logic [4:0] GPR_BANKS = 5'h1F;
	localparam int RAM_BYTES = 64;
	localparam logic [7:0] UNIMPLEMENTED_READ = 8'h00;
	localparam logic [1:0] FLASH_EXTRA_CYCLES = 2'h1;
	typedef enum logic [1:0] {
		ACCESS_IDLE = 2'b00,
		ACCESS_STALL = 2'b01
	} access_state_type;
endpackage

// File: verilog/program_counter.sv
// Fifteen-bit program counter with reset and interrupt vectors.
// Assumes the core supplies load and interrupt requests on the same clock.
`timescale 1ns/10ps
module program_counter (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_advance,
	input wire logic i_load,
	input wire logic [14:0] i_load_addr,
	input wire logic i_interrupt,
	output logic [14:0] o_pc,
	output logic [9:0] o_fetch_addr
);
	logic [14:0] pc;
	logic [14:0] next_pc;

	always_comb begin
		next_pc = pc;
		if (i_interrupt) begin
			next_pc = memory_map_pkg::INTERRUPT_VECTOR;
		end else if (i_load) begin
			next_pc = i_load_addr;
		end else if (i_advance) begin
			next_pc = pc + 15'h0001;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pc <= memory_map_pkg::RESET_VECTOR;
			o_fetch_addr <= 10'h000;
		end else if (i_ce) begin
			pc <= next_pc;
			o_fetch_addr <= next_pc[9:0];
		end
	end

	assign o_pc = pc;
endmodule
